// ---- sim/src_model.sv ----
/*
 src_model: the reset sources facing the controller (pin, watchdog, detector, clocks).
 assumes one clock; every source changes 1 ns after a rising edge.
*/
`timescale 1ns/10ps
module src_model (
   input wire logic clk,
   output logic resetPin_n,
   output reset_ctrl_pkg::held_src_t heldSrc,
   output logic clkStart
);
   initial
   begin
      resetPin_n = 1'b1; // pull-up keeps the open pin high
      heldSrc = '0;
      clkStart = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // pin low for n sampled edges
   task automatic pin(input int n);
      @(posedge clk) #1 resetPin_n = 1'b0;
      repeat (n) @(posedge clk);
      #1 resetPin_n = 1'b1;
   endtask : pin
   task automatic wdt();
      @(posedge clk) #1 heldSrc.wdtOverflow = 1'b1;
      @(posedge clk) #1 heldSrc.wdtOverflow = 1'b0;
   endtask : wdt
   task automatic vd(input logic low, input logic en);
      @(posedge clk) #1 heldSrc.vdLow = low;
      heldSrc.vdResetEn = en;
   endtask : vd
   task automatic startPulse();
      @(posedge clk) #1 clkStart = 1'b1;
      @(posedge clk) #1 clkStart = 1'b0;
   endtask : startPulse
endmodule : src_model

// ---- sim/system_reset_controller_tb_top.sv ----
/*
 system_reset_controller_tb_top: directed scenarios for the reset controller.
 assumes short counts 3/8/8 and the source model beside it.
*/
`timescale 1ns/10ps
module system_reset_controller_tb_top;
   localparam int HOLD = 8;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] softResetBit = 4'h0;
   logic [3:0] moduleEnableBit = 4'hF;
   logic [3:0] enableResets = 4'h0;
   logic resetPin_n, clkStart, heldReset_n, immReset_n;
   logic [3:0] periphReset_n;
   reset_ctrl_pkg::held_src_t heldSrc;
   int miscompares = 0;
   int comparisons = 0;
   int cyc;
   wire [5:0] outs = {heldReset_n, immReset_n, periphReset_n};
   always #12.5 clk = ~clk;
   src_model src_model_i (.clk(clk), .resetPin_n(resetPin_n), .heldSrc(heldSrc),
      .clkStart(clkStart));
   system_reset_controller #(.NUM_PERIPH(4), .PIN_MIN_CYC(3), .HOLD_CYC(HOLD),
      .SETTLE_CYC(8)) system_reset_controller_i (.clk(clk), .rstn(rstn),
      .resetPin_n(resetPin_n), .heldSrc(heldSrc), .clkStart(clkStart),
      .softResetBit(softResetBit), .moduleEnableBit(moduleEnableBit),
      .enableResets(enableResets), .heldReset_n(heldReset_n), .immReset_n(immReset_n),
      .periphReset_n(periphReset_n));
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // edges until the held group lets go; bounded so a stuck reset ends the run
   task automatic lowFor();
      cyc = 0;
      while (heldReset_n !== 1'b1)
      begin
         step(1);
         cyc++;
         if (cyc > 60)
         begin
            chk(6'h00, 6'h01);
            close_out();
         end
      end
   endtask : lowFor
   task automatic quiet(input int n);
      repeat (n)
      begin
         step(1);
         chk(outs, 6'h3F);
      end
   endtask : quiet
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      step(10);
      rstn = 1'b1;
      step(1);
      chk({5'h00, immReset_n}, 6'h01);
      lowFor();
      chk({5'h00, cyc >= 7 && cyc <= 11}, 6'h01);
      step(1);
      chk(outs, 6'h3F);
      $display("boot settle done");
      src_model_i.wdt();
      chk({heldReset_n, immReset_n, 4'h0}, 6'h10);
      lowFor();
      chk({5'h00, cyc >= HOLD && cyc <= HOLD + 3}, 6'h01);
      $display("watchdog hold done");
      src_model_i.pin(2); // too short to qualify
      quiet(8);
      src_model_i.pin(6);
      chk(outs, 6'h00);
      step(2);
      chk({heldReset_n, immReset_n, 4'h0}, 6'h10);
      lowFor();
      quiet(2);
      $display("pin filter done");
      src_model_i.vd(1'b1, 1'b0);
      quiet(6);
      src_model_i.vd(1'b1, 1'b1);
      step(2);
      chk({5'h00, heldReset_n}, 6'h00);
      src_model_i.vd(1'b0, 1'b1);
      lowFor();
      quiet(2);
      $display("voltage detect done");
      softResetBit = 4'h4;
      step(2);
      chk(outs, 6'h3B);
      softResetBit = 4'h0;
      moduleEnableBit = 4'h0; // only peripheral 1 treats a cleared enable as reset
      enableResets = 4'h2;
      step(2);
      chk(outs, 6'h3D);
      moduleEnableBit = 4'hF;
      quiet(2);
      $display("soft resets done");
      src_model_i.startPulse();
      step(1);
      lowFor();
      chk({5'h00, cyc >= 4 && cyc <= 12}, 6'h01);
      $display("clock start done");
      close_out();
   end
endmodule : system_reset_controller_tb_top

// ---- verilog/reset_ctrl_pkg.sv ----
/*
 reset_ctrl_pkg: constants and carrier types for the system reset controller.
 assumes a single 40 MHz system clock; all sources arrive synchronous to it.
*/
package reset_ctrl_pkg;
   localparam int CLK_HZ = 40000000;
   localparam int PIN_MIN_LOW_NS = 2000;
   localparam int PIN_MIN_CYC_RAW = (PIN_MIN_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int PIN_MIN_CYC = (PIN_MIN_CYC_RAW < 1) ? 1 : PIN_MIN_CYC_RAW;
   localparam int HOLD_US = 1000;
   localparam int HOLD_CYC = HOLD_US * (CLK_HZ / 1000000);
   localparam int SETTLE_US = 500;
   localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1000000);
   localparam int NUM_PERIPH = 4;

   typedef struct packed {
      logic pinLow;
      logic wdtOverflow;
      logic vdLow;
      logic vdResetEn;
   } held_src_t;

   typedef enum logic [1:0] {
      ST_SETTLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_RUN = 2'b10
   } hold_state_t;
endpackage : reset_ctrl_pkg

// ---- verilog/system_reset_controller.sv ----
/*
 system_reset_controller: merges pin, watchdog, voltage detector and per-peripheral
 soft resets into a held group, an immediate group and per-peripheral resets, all active low.
 assumes all inputs synchronous to clk; clock-start events arrive as clkStart pulses.
*/
// How it works
// - a pin held low for the minimum time raises a held-group request.
// - low pulses on the pin shorter than that minimum are discarded.
// - a watchdog overflow raises a held-group request.
// - a low-voltage detection requests reset only while its reset function is enabled.
// - a set soft_reset_bit resets that peripheral's control bits via its own reset.
// - per peripheral, a config bit says whether the module_enable_bit clear also resets it.
// - each output group asserts whenever any of its member sources requests.
// - the held group stays in reset a fixed hold time after the last request goes; a clock start in that time ends it and starts the settle.
// - the immediate group releases on the first edge after its request goes.
// - after power-up or a clock start the held group waits a settle time; a request in it, or in the clock-start cycle, starts the hold instead.
`timescale 1ns/10ps
module system_reset_controller #(
   parameter int NUM_PERIPH = reset_ctrl_pkg::NUM_PERIPH,
   parameter int PIN_MIN_CYC = reset_ctrl_pkg::PIN_MIN_CYC,
   parameter int HOLD_CYC = reset_ctrl_pkg::HOLD_CYC,
   parameter int SETTLE_CYC = reset_ctrl_pkg::SETTLE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic resetPin_n,
   input wire reset_ctrl_pkg::held_src_t heldSrc,
   input wire logic clkStart,
   input wire logic [NUM_PERIPH-1:0] softResetBit,
   input wire logic [NUM_PERIPH-1:0] moduleEnableBit,
   input wire logic [NUM_PERIPH-1:0] enableResets,
   output logic heldReset_n,
   output logic immReset_n,
   output logic [NUM_PERIPH-1:0] periphReset_n
);
   localparam int CW = $clog2(HOLD_CYC + SETTLE_CYC + PIN_MIN_CYC + 2);

   initial
   begin
      if (NUM_PERIPH < 1 || PIN_MIN_CYC < 1 || HOLD_CYC < 1 || SETTLE_CYC < 1)
         $error("system_reset_controller: bad parameter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin glitch filter
   logic [CW-1:0] pinCnt_ff;
   logic pinReq_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pinCnt_ff <= '0;
      else if (resetPin_n)
         pinCnt_ff <= '0;
      else if (pinCnt_ff < CW'(PIN_MIN_CYC))
         pinCnt_ff <= pinCnt_ff + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pinReq_ff <= 1'b0;
      else
         pinReq_ff <= !resetPin_n && (pinCnt_ff >= CW'(PIN_MIN_CYC - 1));
   end

   ////////////////////////////////////////////////////////////////////////////
   // held group request and hold counter
   logic heldReq;
   assign heldReq = pinReq_ff || heldSrc.wdtOverflow
      || (heldSrc.vdLow && heldSrc.vdResetEn);

   reset_ctrl_pkg::hold_state_t state_ff;
   logic [CW-1:0] holdCnt_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= reset_ctrl_pkg::ST_SETTLE;
         holdCnt_ff <= '0;
      end
      else if (heldReq)
      begin
         state_ff <= reset_ctrl_pkg::ST_HOLD;
         holdCnt_ff <= '0;
      end
      else if (clkStart)
      begin
         state_ff <= reset_ctrl_pkg::ST_SETTLE;
         holdCnt_ff <= '0;
      end
      else
      begin
         case (state_ff)
            reset_ctrl_pkg::ST_SETTLE:
            begin
               if (holdCnt_ff == CW'(SETTLE_CYC - 1))
               begin
                  state_ff <= reset_ctrl_pkg::ST_RUN;
                  holdCnt_ff <= '0;
               end
               else
                  holdCnt_ff <= holdCnt_ff + 1'b1;
            end
            reset_ctrl_pkg::ST_HOLD:
            begin
               if (holdCnt_ff == CW'(HOLD_CYC - 1))
               begin
                  state_ff <= reset_ctrl_pkg::ST_RUN;
                  holdCnt_ff <= '0;
               end
               else
                  holdCnt_ff <= holdCnt_ff + 1'b1;
            end
            reset_ctrl_pkg::ST_RUN:
               holdCnt_ff <= '0;
            default:
            begin
               state_ff <= reset_ctrl_pkg::ST_SETTLE;
               holdCnt_ff <= '0;
            end
         endcase
      end
   end

   // registered release, never asynchronous
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         heldReset_n <= 1'b0;
      else
         heldReset_n <= (state_ff == reset_ctrl_pkg::ST_RUN) && !heldReq && !clkStart;
   end

   ////////////////////////////////////////////////////////////////////////////
   // immediate group: follows the filtered pin with no hold
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         immReset_n <= 1'b0;
      else
         immReset_n <= !pinReq_ff;
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-peripheral soft reset; also driven by the held group
   // level based: a cleared enable with its config bit keeps the peripheral in reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         periphReset_n <= '0;
      else
         periphReset_n <= ~(softResetBit
            | (enableResets & ~moduleEnableBit)
            | {NUM_PERIPH{!heldReset_n}});
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_reqGone;
      !heldReq && !clkStart && (state_ff == reset_ctrl_pkg::ST_HOLD)
         && (holdCnt_ff == CW'(HOLD_CYC - 1));
   endsequence

   a_hold_release: assert property (@(posedge clk) disable iff (!rstn)
      s_reqGone |=> (state_ff == reset_ctrl_pkg::ST_RUN) ##1 heldReset_n)
      else $error("held reset did not release after hold");
   a_req_asserts: assert property (@(posedge clk) disable iff (!rstn)
      heldSrc.wdtOverflow |=> !heldReset_n)
      else $error("watchdog overflow did not reset");
   a_vd_gated: assert property (@(posedge clk) disable iff (!rstn)
      (heldSrc.vdLow && heldSrc.vdResetEn) |=> !heldReset_n)
      else $error("enabled low voltage did not reset");
   a_glitch_blocked: assert property (@(posedge clk) disable iff (!rstn)
      $rose(pinReq_ff) |-> $past(!resetPin_n, 1) && $past(!resetPin_n, 2))
      else $error("pin request without sustained low");
   a_pin_request: assert property (@(posedge clk) disable iff (!rstn)
      (!resetPin_n && pinCnt_ff == CW'(PIN_MIN_CYC)) |=> pinReq_ff)
      else $error("long pin low did not request");
   a_imm_release: assert property (@(posedge clk) disable iff (!rstn)
      $fell(pinReq_ff) |=> immReset_n)
      else $error("immediate group held too long");
   a_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
      (softResetBit != '0) |=> ((periphReset_n & $past(softResetBit)) == '0))
      else $error("soft reset bit ignored");
   a_enable_clear: assert property (@(posedge clk) disable iff (!rstn)
      ((enableResets & ~moduleEnableBit) != '0)
         |=> ((periphReset_n & $past(enableResets & ~moduleEnableBit)) == '0))
      else $error("configured enable clear did not reset");
   a_periph_held: assert property (@(posedge clk) disable iff (!rstn)
      !heldReset_n |=> (periphReset_n == '0))
      else $error("peripheral reset missed held group");
   a_pin_groups: assert property (@(posedge clk) disable iff (!rstn)
      $rose(pinReq_ff) |=> (!immReset_n && !heldReset_n))
      else $error("pin request did not reset both groups");
   a_vd_masked: assert property (@(posedge clk) disable iff (!rstn)
      (heldSrc.vdLow && !heldSrc.vdResetEn && !heldReq && !clkStart
         && (state_ff == reset_ctrl_pkg::ST_RUN)) |=> heldReset_n)
      else $error("disabled low voltage caused reset");
   // counter must never run past the hold end, else release would be lost
   a_hold_bound: assert property (@(posedge clk) disable iff (!rstn)
      (state_ff == reset_ctrl_pkg::ST_HOLD) |-> (holdCnt_ff < CW'(HOLD_CYC)))
      else $error("hold counter overran");
   a_enable_reset: assert property (@(posedge clk) disable iff (!rstn)
      (!enableResets[0] && !softResetBit[0] && heldReset_n) |=> periphReset_n[0])
      else $error("module enable reset without config");
   a_settle_wait: assert property (@(posedge clk) disable iff (!rstn)
      (clkStart && !heldReq) |=> (state_ff == reset_ctrl_pkg::ST_SETTLE) && !heldReset_n)
      else $error("clock start did not enter settle");
   a_sync_release: assert property (@(posedge clk) disable iff (!rstn)
      $rose(heldReset_n) |-> $past(state_ff == reset_ctrl_pkg::ST_RUN))
      else $error("release not from run state");
endmodule : system_reset_controller
